// ===== hdl/useq_pkg.sv
// package: microword field layout, sequencer opcodes, condition codes, address alu codes
package useq_pkg;
    // ------------------------------------------------------------
    // microword layout
    // ------------------------------------------------------------
    localparam int UW_W        = 66;
    localparam int SEQ_OP_LO   = 0;
    localparam int COND_LO     = 4;
    localparam int JADDR_LO    = 8;
    localparam int LIT_LO      = 4;
    localparam int DSEL_SEQ    = 20;
    localparam int AREG_LO     = 21;
    localparam int BREG_LO     = 25;
    localparam int SRC_LO      = 29;
    localparam int FUNC_LO     = 31;
    localparam int DEST_BIT    = 33;
    localparam int CIN_BIT     = 34;
    localparam int DSEL_ADR    = 35;
    localparam int UADDR_W     = 12;
    localparam int DATA_W      = 16;
    localparam int NREG        = 16;
    localparam int STACK_D     = 5;
    localparam logic [UADDR_W-1:0] UADDR_RST = 12'h000;
    localparam logic [DATA_W-1:0]  REG_RST   = 16'h0000;

    // ------------------------------------------------------------
    // sequencer operations
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        jump_to_address_null       = 4'h0,
        cond_call_pipeline         = 4'h1,
        jump_mapped                = 4'h2,
        cond_jump_pipeline         = 4'h3,
        push_cond_load             = 4'h4,
        cond_call_reg_or_pipe      = 4'h5,
        cond_jump_vector           = 4'h6,
        cond_jump_reg_or_pipe      = 4'h7,
        repeat_loop_counter_nonnull = 4'h8,
        repeat_pipe_counter_nonnull = 4'h9,
        cond_subroutine_return     = 4'ha,
        cond_jump_pipe_pop         = 4'hb,
        load_counter_and_advance   = 4'hc,
        loop_end_test              = 4'hd,
        advance_sequential         = 4'he,
        three_way_branch           = 4'hf
    } seq_op_e;

    // ------------------------------------------------------------
    // branch condition table (codes are a parameter choice)
    // ------------------------------------------------------------
    localparam logic [3:0] COND_ONE  = 4'h0;
    localparam logic [3:0] COND_ZERO = 4'h1;
    localparam logic [3:0] COND_SIGN = 4'h2;
    localparam logic [3:0] COND_CARRY = 4'h3;
    localparam logic [3:0] COND_OVERFLOW = 4'h4;
    localparam logic [3:0] COND_LEZ  = 4'h5;
    localparam int COND_INV_BIT = 3;

    // ------------------------------------------------------------
    // address alu codes
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_AB  = 2'b00;
    localparam logic [1:0] SRC_DEXT_NULL = 2'b01;
    localparam logic [1:0] SRC_NULL_REGA = 2'b10;
    localparam logic [1:0] SRC_DEXT_REGA = 2'b11;
    localparam logic [1:0] FN_ADD  = 2'b00;
    localparam logic [1:0] FN_REV_SUB = 2'b01;
    localparam logic [1:0] FN_AND  = 2'b10;
    localparam logic [1:0] FN_OR   = 2'b11;

    typedef struct packed {
        logic zero;
        logic sign;
        logic carry;
        logic overflow;
    } alu_flags_s;

    typedef struct packed {
        logic [3:0]  a_sel;
        logic [3:0]  b_sel;
        logic [1:0]  src;
        logic [1:0]  func;
        logic        dest_wr;
        logic        cin;
        logic [15:0] dext;
    } adr_ctl_s;
endpackage

// ===== hdl/cond_select.sv
// branch condition multiplexer over data alu flags
`timescale 1ns/100ps
module cond_select (
    input  wire logic [3:0]          code,
    input  wire useq_pkg::alu_flags_s flags,
    output logic                     pass
);
    import useq_pkg::*;
    logic base;
    always_comb begin
        unique case (code[2:0])
            COND_ONE[2:0]:   base = 1'b1;
            COND_ZERO[2:0]:  base = flags.zero;
            COND_SIGN[2:0]:  base = flags.sign;
            COND_CARRY[2:0]: base = flags.carry;
            COND_OVERFLOW[2:0]: base = flags.overflow;
            COND_LEZ[2:0]:   base = flags.zero | (flags.sign ^ flags.overflow);
            default:         base = 1'b1;
        endcase
    end
    // upper bit inverts: nonzero, positive, no carry, no overflow, above zero
    assign pass = code[COND_INV_BIT] ? ~base : base;
endmodule // cond_select

// ===== hdl/addr_alu.sv
// sixteen-register address alu
`timescale 1ns/100ps
module addr_alu (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire useq_pkg::adr_ctl_s  ctl,
    output logic [15:0]              y
);
    import useq_pkg::*;
    logic [15:0] regs [NREG];
    logic [15:0] ra, rb, r, s, f;
    logic [16:0] sum;

    assign ra = regs[ctl.a_sel];
    assign rb = regs[ctl.b_sel];

    always_comb begin
        unique case (ctl.src)
            SRC_AB: begin r = ra;       s = rb;    end
            SRC_DEXT_NULL: begin r = ctl.dext; s = '0;    end
            SRC_NULL_REGA: begin r = '0;       s = ra;    end
            SRC_DEXT_REGA: begin r = ctl.dext; s = ra;    end
        endcase
    end

    always_comb begin
        sum = '0;
        unique case (ctl.func)
            FN_ADD:  sum = {1'b0, r} + {1'b0, s} + {16'h0000, ctl.cin};
            FN_REV_SUB: sum = {1'b0, s} + {1'b0, ~r} + {16'h0000, ctl.cin};
            FN_AND:  sum = {1'b0, r & s};
            FN_OR:   sum = {1'b0, r | s};
        endcase
        f = sum[15:0];
    end

    // defaults (literal and zero, and) give zero and keep every register
    assign y = f;

    generate
        for (genvar i = 0; i < NREG; i++) begin : g_reg
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    regs[i] <= REG_RST;
                end else if (ctl.dest_wr && ctl.b_sel == 4'(i)) begin
                    regs[i] <= f;
                end
            end
        end
    endgenerate
endmodule // addr_alu

// ===== hdl/microword_seq_addr_decode.sv
// microword decoder: sequencer and address generation fields
`timescale 1ns/100ps
module microword_seq_addr_decode (
    input  wire logic [useq_pkg::UW_W-1:0]    uword,
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire logic [15:0]                  data_y,
    input  wire useq_pkg::alu_flags_s         flags,
    input  wire logic [useq_pkg::UADDR_W-1:0] map_addr,
    input  wire logic [useq_pkg::UADDR_W-1:0] vector_addr,
    output logic [useq_pkg::UADDR_W-1:0]      next_uaddr,
    output logic [15:0]                       addr_y,
    output logic                              cond_pass,
    output logic [useq_pkg::UADDR_W-1:0]      loop_count,
    output logic [2:0]                        stack_depth
);
    import useq_pkg::*;
    // ------------------------------------------------------------
    // field split
    // ------------------------------------------------------------
    seq_op_e              op;
    logic [3:0]           cond_code;
    logic [UADDR_W-1:0]   seq_d;
    adr_ctl_s             actl;

    assign op        = seq_op_e'(uword[SEQ_OP_LO +: 4]);
    assign cond_code = uword[COND_LO +: 4];
    // bits 4-19 feed the address alu and the sequencer; microcode keeps them consistent
    assign seq_d = uword[DSEL_SEQ] ? data_y[UADDR_W-1:0]
                                   : uword[JADDR_LO +: UADDR_W];

    always_comb begin
        actl.a_sel   = uword[AREG_LO +: 4];
        actl.b_sel   = uword[BREG_LO +: 4];
        actl.src     = uword[SRC_LO +: 2];
        actl.func    = uword[FUNC_LO +: 2];
        actl.dest_wr = uword[DEST_BIT];
        actl.cin     = uword[CIN_BIT];
        actl.dext    = uword[DSEL_ADR] ? data_y : uword[LIT_LO +: DATA_W];
    end

    // ------------------------------------------------------------
    // condition test and address alu
    // ------------------------------------------------------------
    logic pass;
    cond_select u_cond (
        .code  (cond_code),
        .flags (flags),
        .pass  (pass)
    );
    assign cond_pass = pass;

    addr_alu u_aalu (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ctl     (actl),
        .y       (addr_y)
    );

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    logic [UADDR_W-1:0] upc;
    logic [UADDR_W-1:0] counter;
    logic [UADDR_W-1:0] stack [STACK_D];
    logic [2:0]         sp;
    logic [UADDR_W-1:0] tos;
    logic               cnt_zero;
    logic               do_push, do_pop, do_load, do_dec, do_clear;
    logic [UADDR_W-1:0] next_addr;

    assign tos      = (sp == 3'd0) ? '0 : stack[sp - 3'd1];
    assign cnt_zero = (counter == '0);

    always_comb begin
        next_addr = upc;
        do_push = 1'b0;
        do_pop = 1'b0;
        do_load = 1'b0;
        do_dec = 1'b0;
        do_clear = 1'b0;
        unique case (op)
            jump_to_address_null: begin
                next_addr = '0;
                do_clear = 1'b1;
            end
            cond_call_pipeline: begin
                if (pass) begin
                    next_addr = seq_d;
                    do_push = 1'b1;
                end
            end
            jump_mapped:      next_addr = map_addr;
            cond_jump_pipeline: begin
                if (pass) next_addr = seq_d;
            end
            push_cond_load: begin
                do_push = 1'b1;
                do_load = pass;
            end
            cond_call_reg_or_pipe: begin
                next_addr = pass ? seq_d : counter;
                do_push = 1'b1;
            end
            cond_jump_vector: begin
                if (pass) next_addr = vector_addr;
            end
            cond_jump_reg_or_pipe: next_addr = pass ? seq_d : counter;
            repeat_loop_counter_nonnull: begin
                if (!cnt_zero) begin
                    next_addr = tos;
                    do_dec = 1'b1;
                end else begin
                    do_pop = 1'b1;
                end
            end
            repeat_pipe_counter_nonnull: begin
                if (!cnt_zero) begin
                    next_addr = seq_d;
                    do_dec = 1'b1;
                end
            end
            cond_subroutine_return: begin
                if (pass) begin
                    next_addr = tos;
                    do_pop = 1'b1;
                end
            end
            cond_jump_pipe_pop: begin
                if (pass) begin
                    next_addr = seq_d;
                    do_pop = 1'b1;
                end
            end
            load_counter_and_advance: do_load = 1'b1;
            loop_end_test: begin
                if (pass) do_pop = 1'b1;
                else next_addr = tos;
            end
            advance_sequential: next_addr = upc;
            three_way_branch: begin
                if (pass) begin
                    do_pop = 1'b1;
                end else if (cnt_zero) begin
                    next_addr = seq_d;
                    do_pop = 1'b1;
                end else begin
                    next_addr = tos;
                    do_dec = 1'b1;
                end
            end
        endcase
    end

    assign next_uaddr  = next_addr;
    assign loop_count  = counter;
    assign stack_depth = sp;

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            upc <= UADDR_RST;
        end else begin
            upc <= next_addr + 12'h001;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            counter <= UADDR_RST;
        end else if (do_load) begin
            counter <= seq_d;
        end else if (do_dec) begin
            counter <= counter - 12'h001;
        end
    end

    // stack overflow keeps the top entry rewritten; depth saturates at five
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sp <= 3'd0;
        end else if (do_clear) begin
            sp <= 3'd0;
        end else if (do_push && sp != 3'(STACK_D)) begin
            sp <= sp + 3'd1;
        end else if (do_pop && sp != 3'd0) begin
            sp <= sp - 3'd1;
        end
    end

    generate
        for (genvar i = 0; i < STACK_D; i++) begin : g_stk
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    stack[i] <= UADDR_RST;
                end else if (do_push && (3'(i) == ((sp == 3'(STACK_D)) ? sp - 3'd1 : sp))) begin
                    stack[i] <= upc;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_advance_step: assert property (op == advance_sequential |-> next_uaddr == upc)
        else $error("advance did not step");
    a_null_jump: assert property (op == jump_to_address_null |=> sp == 3'd0 && upc == 12'h001)
        else $error("null jump wrong");
    a_three_pass: assert property (op == three_way_branch && pass && sp != 3'd0
        |=> sp == $past(sp) - 3'd1)
        else $error("three-way pass did not pop");
    a_three_loop: assert property (op == three_way_branch && !pass && !cnt_zero
        |=> counter == $past(counter) - 12'h001)
        else $error("three-way loop did not count");
    a_three_exit: assert property (op == three_way_branch && !pass && cnt_zero
        |-> next_uaddr == seq_d)
        else $error("three-way exit missed target");
    a_three_advance_sequential: assert property (op == three_way_branch && pass |-> next_uaddr == upc)
        else $error("three-way pass did not advance");
    a_cond_force: assert property (cond_code == COND_ONE |-> cond_pass)
        else $error("forced condition false");
    a_cond_false: assert property (cond_code == (COND_ONE | 4'h8) |-> !cond_pass)
        else $error("inverted forced condition true");
    a_dsel_seq: assert property (op == load_counter_and_advance && uword[DSEL_SEQ]
        |=> counter == $past(data_y[11:0]))
        else $error("counter not loaded from data alu");
    a_load_lit: assert property (op == load_counter_and_advance && !uword[DSEL_SEQ]
        |=> counter == $past(uword[19:8]))
        else $error("counter not loaded from literal");
    a_load_push: assert property (op == push_cond_load && pass |=> counter == $past(seq_d))
        else $error("push did not load counter");
    a_counter_hold: assert property (!do_load && !do_dec |=> counter == $past(counter))
        else $error("counter changed unasked");
    a_jump_lit: assert property (op == cond_jump_pipeline && pass && !uword[DSEL_SEQ]
        |-> next_uaddr == uword[19:8])
        else $error("jump target not from literal");
    a_reg_fail: assert property (op == cond_jump_reg_or_pipe && !pass |-> next_uaddr == counter)
        else $error("failed jump did not use counter");
    a_return_top: assert property (op == cond_subroutine_return && pass |-> next_uaddr == tos)
        else $error("return did not use stack top");
    a_loop_back: assert property (op == repeat_loop_counter_nonnull && !cnt_zero
        |-> next_uaddr == tos)
        else $error("loop did not return to top");
    a_call_push: assert property (op == cond_call_pipeline && pass && sp != 3'(STACK_D)
        |=> sp == $past(sp) + 3'd1)
        else $error("call did not push");
    a_push_full: assert property (do_push && sp == 3'(STACK_D) |=> sp == 3'(STACK_D))
        else $error("full stack depth moved");
    a_stack_bound: assert property (stack_depth <= 3'(STACK_D))
        else $error("stack depth out of range");
    a_upc_step: assert property (1'b1 |=> upc == $past(next_addr) + 12'h001)
        else $error("address counter did not step");

    // ------------------------------------------------------------
    // address alu checks
    // ------------------------------------------------------------
    a_addr_default: assert property (actl.src == SRC_DEXT_NULL && actl.func == FN_AND
        |-> addr_y == 16'h0000)
        else $error("default address field not zero");
    a_ext_data: assert property (uword[DSEL_ADR] |-> actl.dext == data_y)
        else $error("data alu not on address input");
    a_carry_in: assert property (actl.src == SRC_DEXT_NULL && actl.func == FN_ADD
        |-> addr_y == actl.dext + 16'(actl.cin))
        else $error("carry in not applied");
    a_addr_dsel: assert property (!uword[DSEL_ADR] && actl.src == SRC_DEXT_NULL && actl.func == FN_OR
        |-> addr_y == uword[19:4])
        else $error("literal not on address input");
    a_addr_write: assert property (actl.src == SRC_DEXT_NULL && actl.func == FN_OR && actl.dest_wr
        ##1 actl.src == SRC_NULL_REGA && actl.func == FN_OR
        && actl.a_sel == $past(actl.b_sel)
        |-> addr_y == $past(addr_y))
        else $error("register b write lost");

    c_call: cover property (op == cond_call_pipeline && pass);
    c_three_jump: cover property (op == three_way_branch && !pass && cnt_zero);
    c_loop: cover property (op == repeat_loop_counter_nonnull && !cnt_zero);
    c_addr_wr: cover property (actl.dest_wr && actl.src == SRC_DEXT_REGA);
    c_stack_full: cover property (stack_depth == 3'(STACK_D));
endmodule // microword_seq_addr_decode

// ===== sim/alu_side_model.sv
// far-side model: data alu result, status flags and jump address sources
`timescale 1ns/100ps
module alu_side_model (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    output logic [15:0]                  data_y,
    output useq_pkg::alu_flags_s         flags,
    output logic [useq_pkg::UADDR_W-1:0] map_addr,
    output logic [useq_pkg::UADDR_W-1:0] vector_addr
);
    import useq_pkg::*;
    // ------------------------------------------------------------
    // fresh values every cycle
    // ------------------------------------------------------------
    // a held value would hide a select that reads the wrong cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_y      <= 16'h0000;
            flags       <= '0;
            map_addr    <= 12'h000;
            vector_addr <= 12'h000;
        end else begin
            data_y      <= 16'($urandom);
            flags       <= alu_flags_s'(4'($urandom));
            map_addr    <= 12'($urandom);
            vector_addr <= 12'($urandom);
        end
    end
endmodule // alu_side_model

// ===== sim/microword_seq_addr_decode_tb.sv
// self-checking bench for the sequencer and address field decoder
`timescale 1ns/100ps
module microword_seq_addr_decode_tb;
    import useq_pkg::*;
    typedef struct packed {
        logic [11:0] nx;
        logic [15:0] ay;
        logic        cp;
        logic        mcp;
        logic [11:0] lc;
        logic [2:0]  sd;
    } note_s;
    logic               clk;
    logic               sys_rst;
    logic [UW_W-1:0]    uword;
    logic [15:0]        data_y;
    logic [15:0]        addr_y;
    alu_flags_s         flags;
    logic [UADDR_W-1:0] map_addr;
    logic [UADDR_W-1:0] vector_addr;
    logic [UADDR_W-1:0] next_uaddr;
    logic [UADDR_W-1:0] loop_count;
    logic               cond_pass;
    logic [2:0]         stack_depth;
    note_s              q[$];
    note_s              nt;
    int                 mismatches;
    int                 checks;
    int                 cyc;
    int                 sp;
    logic [11:0]        upc;
    logic [11:0]        cnt;
    logic [11:0]        stk[5];
    logic [15:0]        regs[16];

    microword_seq_addr_decode dut (.uword(uword), .clk(clk), .sys_rst(sys_rst), .data_y(data_y),
        .flags(flags), .map_addr(map_addr), .vector_addr(vector_addr), .next_uaddr(next_uaddr),
        .addr_y(addr_y), .cond_pass(cond_pass), .loop_count(loop_count), .stack_depth(stack_depth));
    alu_side_model far (.clk(clk), .sys_rst(sys_rst), .data_y(data_y), .flags(flags),
        .map_addr(map_addr), .vector_addr(vector_addr));

    // ------------------------------------------------------------
    // word building
    // ------------------------------------------------------------
    // one literal feeds both condition/jump and address input, so no conflict
    function automatic logic [UW_W-1:0] mk(input logic [3:0] op, input logic [15:0] lit, input logic ds,
        input logic [3:0] a, input logic [3:0] b, input logic [1:0] src, input logic [1:0] fn,
        input logic dst, input logic ci, input logic da);
        logic [UW_W-1:0] w;
        w = UW_W'({$urandom, $urandom, $urandom}); // upper fields are noise here
        w[SEQ_OP_LO +: 4] = op;
        w[LIT_LO +: 16] = lit;
        w[DSEL_SEQ] = ds;
        w[AREG_LO +: 4] = a;
        w[BREG_LO +: 4] = b;
        w[SRC_LO +: 2] = src;
        w[FUNC_LO +: 2] = fn;
        w[DEST_BIT] = dst;
        w[CIN_BIT] = ci;
        w[DSEL_ADR] = da;
        return w;
    endfunction

    function automatic logic [UW_W-1:0] dw(input logic [3:0] op, input logic [15:0] lit, input logic ds);
        return mk(op, lit, ds, 4'($urandom), 4'($urandom), SRC_DEXT_NULL, FN_AND, 1'b0, 1'b0, 1'b0);
    endfunction

    // codes 6, 7, e, f are unassigned and kept out
    function automatic logic [UW_W-1:0] rw(input logic [3:0] op);
        logic [3:0] c;
        c = 4'($urandom % 12);
        if (c > 4'd5) c = c + 4'd2;
        return mk(op, {12'($urandom), c}, 1'($urandom), 4'($urandom), 4'($urandom), 2'($urandom),
            2'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    endfunction

    // ------------------------------------------------------------
    // reference model and driver
    // ------------------------------------------------------------
    task automatic push(input logic [11:0] v);
        if (sp == STACK_D) stk[STACK_D-1] = v;
        else begin
            stk[sp] = v;
            sp++;
        end
    endtask

    task automatic pop();
        if (sp > 0) sp--;
    endtask

    task automatic step(input logic [UW_W-1:0] w);
        note_s n;
        logic [15:0] d, r, s, y, ra;
        logic [11:0] dq, pc, top;
        logic [3:0] c;
        logic p;
        uword = w;
        c = w[COND_LO +: 4];
        pc = upc;
        top = (sp > 0) ? stk[sp-1] : 12'h000;
        dq = w[DSEL_SEQ] ? data_y[11:0] : w[JADDR_LO +: 12];
        case (c & 4'h7)
            COND_ONE:   p = 1'b1;
            COND_ZERO:  p = flags.zero;
            COND_SIGN:  p = flags.sign;
            COND_CARRY: p = flags.carry;
            COND_OVERFLOW: p = flags.overflow;
            default:    p = flags.zero | (flags.sign ^ flags.overflow);
        endcase
        n.cp = p ^ c[COND_INV_BIT];
        p = n.cp;
        n.mcp = (c & 4'h7) > COND_LEZ;
        n.lc = cnt;
        n.sd = 3'(sp);
        d = w[DSEL_ADR] ? data_y : w[LIT_LO +: 16];
        ra = regs[w[AREG_LO +: 4]];
        case (w[SRC_LO +: 2])
            SRC_AB: begin r = ra; s = regs[w[BREG_LO +: 4]]; end
            SRC_DEXT_NULL: begin r = d; s = 16'h0000; end
            SRC_NULL_REGA: begin r = 16'h0000; s = ra; end
            default: begin r = d; s = ra; end
        endcase
        case (w[FUNC_LO +: 2])
            FN_ADD:  y = r + s + 16'(w[CIN_BIT]);
            FN_REV_SUB: y = s + ~r + 16'(w[CIN_BIT]);
            FN_AND:  y = r & s;
            default: y = r | s;
        endcase
        n.ay = y;
        if (w[DEST_BIT]) regs[w[BREG_LO +: 4]] = y;
        n.nx = pc;
        case (w[3:0])
            4'h0: begin n.nx = 12'h000; sp = 0; end
            4'h1: if (p) begin push(pc); n.nx = dq; end
            4'h2: n.nx = map_addr;
            4'h3: if (p) n.nx = dq;
            4'h4: begin push(pc); if (p) cnt = dq; end
            4'h5: begin push(pc); n.nx = p ? dq : cnt; end
            4'h6: if (p) n.nx = vector_addr;
            4'h7: n.nx = p ? dq : cnt;
            4'h8: if (cnt != 12'h000) begin n.nx = top; cnt--; end else pop();
            4'h9: if (cnt != 12'h000) begin n.nx = dq; cnt--; end
            4'ha: if (p) begin n.nx = top; pop(); end
            4'hb: if (p) begin n.nx = dq; pop(); end
            4'hc: cnt = dq;
            4'hd: if (p) pop(); else n.nx = top;
            4'hf: if (p) pop(); else if (cnt == 12'h000) begin n.nx = dq; pop(); end
                  else begin n.nx = top; cnt--; end
            default: ;
        endcase
        upc = n.nx + 12'h001;
        q.push_back(n);
        @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk) begin
        if (q.size() > 0) begin
            nt = q.pop_front();
            chk(16'(next_uaddr), 16'(nt.nx));
            chk(addr_y, nt.ay);
            if (!nt.mcp) chk(16'(cond_pass), 16'(nt.cp));
            chk(16'(loop_count), 16'(nt.lc));
            chk(16'(stack_depth), 16'(nt.sd));
        end
    end

    // hang guard well above the few hundred cycles of stimulus
    always @(posedge clk) begin
        cyc++;
        if (cyc >= 3000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(16462));
        sys_rst = 1'b1;
        uword = dw(advance_sequential, 16'h0000, 1'b0);
        upc = 12'h000;
        cnt = 12'h000;
        sp = 0;
        foreach (regs[i]) regs[i] = REG_RST;
        mismatches = 0;
        checks = 0;
        cyc = 0;
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (3) step(dw(advance_sequential, 16'($urandom), 1'b0));
        for (int i = 0; i < 16; i++) step(rw(4'(i)));
        step(dw(push_cond_load, {12'h002, COND_ONE}, 1'b0));
        repeat (3) step(dw(three_way_branch, {12'h040, COND_ONE | 4'h8}, 1'b0));
        step(dw(push_cond_load, {12'h000, COND_ONE | 4'h8}, 1'b0));
        step(dw(three_way_branch, {12'h040, COND_ONE}, 1'b0));
        repeat (7) step(dw(cond_call_pipeline, {12'($urandom), COND_ONE}, 1'b0));
        repeat (7) step(dw(cond_subroutine_return, {12'h000, COND_ONE}, 1'b0));
        step(dw(load_counter_and_advance, 16'($urandom), 1'b1));
        repeat (4) step(rw(repeat_pipe_counter_nonnull));
        for (int i = 0; i < 16; i++)
            step(mk(advance_sequential, 16'($urandom), 1'b0, 4'($urandom), 4'($urandom), 2'(i), 2'(i >> 2),
                1'b1, 1'($urandom), 1'($urandom)));
        // write register 3, then read it back through the A port
        step(mk(advance_sequential, 16'($urandom), 1'b0, 4'h0, 4'h3, SRC_DEXT_NULL, FN_OR, 1'b1, 1'b0, 1'b0));
        step(mk(advance_sequential, 16'($urandom), 1'b0, 4'h3, 4'h0, SRC_NULL_REGA, FN_OR, 1'b0, 1'b0, 1'b0));
        repeat (300) step(rw(4'($urandom)));
        final_report();
    end
endmodule // microword_seq_addr_decode_tb
